//--- hdl/alu_jump_pkg.sv
// Purpose: shared constants and types for the execution datapath
// Assumes: one core clock, operands supplied by the decoder and register file
// Notes:   register indices, flag positions and cycle counts live here

package alu_jump_pkg;

	// ---------------------------------------------------------------
	// instruction selector handed over by the decoder
	// ---------------------------------------------------------------
	typedef enum logic [4:0] {
		OP_NONE,
		OP_REG_ADD,
		OP_REG_ADD_CARRY,
		OP_WORD_ADD_IMM,
		OP_REG_SUB,
		OP_REG_SUB_BORROW,
		OP_CONST_SUB,
		OP_CONST_SUB_BORROW,
		OP_WORD_SUB_IMM,
		OP_REG_AND,
		OP_CONST_AND,
		OP_REG_OR,
		OP_CONST_OR,
		OP_REG_XOR,
		OP_BIT_SET_MASK,
		OP_BIT_CLEAR_MASK,
		OP_ZERO_MINUS_CHECK,
		OP_BIT_INVERSION,
		OP_ARITH_INVERT,
		OP_UNSIGNED_PRODUCT,
		OP_SIGNED_PRODUCT,
		OP_MIXED_PRODUCT,
		OP_FRAC_UNSIGNED,
		OP_FRAC_SIGNED,
		OP_FRAC_MIXED,
		OP_REL_BRANCH,
		OP_REL_INVOKE,
		OP_DIRECT_JUMP,
		OP_PTR_BRANCH,
		OP_PTR_INVOKE
	} op_t;

	// ---------------------------------------------------------------
	// status flag positions
	// ---------------------------------------------------------------
	localparam int FLAG_CARRY  = 0;
	localparam int FLAG_NULL   = 1;
	localparam int FLAG_TOP    = 2;
	localparam int FLAG_RANGE  = 3;
	localparam int FLAG_SIGN   = 4;
	localparam int FLAG_NIBBLE = 5;

	localparam logic [7:0]  STATUS_RESET  = 8'h00;
	localparam logic [15:0] COUNTER_RESET = 16'h0000;
	localparam logic [15:0] PRODUCT_RESET = 16'h0000;

	// ---------------------------------------------------------------
	// register port indices
	// ---------------------------------------------------------------
	localparam logic [2:0] REG_STATUS     = 3'h0;
	localparam logic [2:0] REG_COUNTER_LO = 3'h1;
	localparam logic [2:0] REG_COUNTER_HI = 3'h2;
	localparam logic [2:0] REG_PRODUCT_LO = 3'h3;
	localparam logic [2:0] REG_PRODUCT_HI = 3'h4;
	localparam logic [2:0] REG_RESULT     = 3'h5;

	// ---------------------------------------------------------------
	// cycle counts per instruction class
	// ---------------------------------------------------------------
	localparam logic [1:0] ALU_CYCLES        = 2'd1;
	localparam logic [1:0] WORD_CYCLES       = 2'd2;
	localparam logic [1:0] MUL_CYCLES        = 2'd2;
	localparam logic [1:0] REL_BRANCH_CYCLES = 2'd2;
	localparam logic [1:0] PTR_BRANCH_CYCLES = 2'd2;
	localparam logic [1:0] DIRECT_CYCLES     = 2'd3;
	localparam logic [1:0] PTR_INVOKE_CYCLES = 2'd3;
	localparam logic [1:0] REL_INVOKE_CYCLES = 2'd3;

endpackage

//--- hdl/product_unit.sv
// Purpose: 8x8 multiplier stage with signed, mixed and fractional forms
// Assumes: operands held stable by the caller for the whole operation
// Notes:   one register stage, so the product is ready one edge after operands

`timescale 1ns/1ps

module product_unit (
	input  wire logic        core_clk,   // core clock
	input  wire logic        rstn,       // async reset, active low
	input  wire logic [7:0]  opA,        // first operand
	input  wire logic [7:0]  opB,        // second operand
	input  wire logic        signA,      // first operand is signed
	input  wire logic        signB,      // second operand is signed
	input  wire logic        fractional, // shift product left by one
	output logic      [15:0] product,    // registered product
	output logic             carryOut    // registered carry flag
);
	import alu_jump_pkg::*;

	logic [15:0] extA;
	logic [15:0] extB;
	logic [15:0] rawProduct;

	// sign extension picks the signedness without separate multipliers
	assign extA       = {{8{signA & opA[7]}}, opA};
	assign extB       = {{8{signB & opB[7]}}, opB};
	assign rawProduct = 16'(extA * extB);

	// carry reflects the top bit before the fractional shift
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			product  <= PRODUCT_RESET;
			carryOut <= 1'b0;
		end else begin
			product  <= fractional ? {rawProduct[14:0], 1'b0} : rawProduct;
			carryOut <= rawProduct[15];
		end
	end

endmodule

//--- hdl/arith_logic_multiply_jump_unit.sv
// Purpose: execution datapath for byte, word, logic, multiply and jump work
// Assumes: decoder issues only while busy is low; operands valid with issue
// Notes:   results, flags and counter change together on the done edge
//
// Operation
// - register add and add-with-carry, flags Z C N V H, one cycle
// - word pair plus constant, flags Z C N V S, two cycles
// - register subtract and borrow form, flags Z C N V H, one cycle
// - destination minus constant, flags Z C N V H, one cycle
// - destination minus constant minus carry, flags Z C N V H, one cycle
// - word pair minus constant, flags Z C N V S, two cycles
// - and with register or constant, flags Z N V only, one cycle
// - or with register or constant, xor registers, Z N V, one cycle
// - set mask ors constant into destination, Z N V, one cycle
// - clear mask ands with ff minus mask, Z N V, one cycle
// - test ands destination with itself, Z N V, one cycle
// - unsigned, signed, mixed products into product pair, Z C, two cycles
// - fractional products shifted left one into product pair, two cycles
// - pointer branch loads counter from pointer pair, flags kept, two cycles
// - pointer invoke moves to pointer pair, flags kept, three cycles

`timescale 1ns/1ps

module arith_logic_multiply_jump_unit (
	input  wire logic                core_clk,       // core clock, 100 MHz
	input  wire logic                rstn,           // async reset, active low
	input  wire logic                issueValid,     // decoder issues an op
	input  wire alu_jump_pkg::op_t   issueOp,        // op selector
	input  wire logic [7:0]          destValue,      // destination register
	input  wire logic [7:0]          secondSource,   // second source register
	input  wire logic [7:0]          immediateValue, // byte constant or mask
	input  wire logic [15:0]         wordPairValue,  // high:low word pair
	input  wire logic [5:0]          wordImmediate,  // word constant
	input  wire logic [15:0]         pointerPair,    // pointer register pair
	input  wire logic [11:0]         jumpOffset,     // signed relative offset
	input  wire logic [15:0]         jumpTarget,     // direct jump address
	input  wire logic [2:0]          regAddr,        // register port index
	input  wire logic [7:0]          regWrData,      // register write data
	input  wire logic                regWrite,       // register write strobe
	input  wire logic                regRead,        // register read strobe
	output logic      [7:0]          regRdData,      // read data, next cycle
	output logic                     busy,           // op in flight
	output logic                     done,           // op finished, pulse
	output logic                     destWrite,      // write destination, pulse
	output logic      [7:0]          destResult,     // destination result
	output logic                     wordWrite,      // write word pair, pulse
	output logic      [15:0]         wordResult,     // word pair result
	output logic                     productWrite,   // write product pair, pulse
	output logic      [15:0]         productPair,    // multiply result
	output logic      [7:0]          statusFlags,    // status flags
	output logic      [15:0]         programCounter, // program counter
	output logic                     callPush,       // push return address
	output logic      [15:0]         returnAddr      // address to push
);
	import alu_jump_pkg::*;

	// ---------------------------------------------------------------
	// operands held for the life of an op
	// ---------------------------------------------------------------
	op_t         opReg;
	logic [7:0]  dReg;
	logic [7:0]  sReg;
	logic [7:0]  kReg;
	logic [15:0] wReg;
	logic [5:0]  wkReg;
	logic [15:0] ptrReg;
	logic [11:0] offReg;
	logic [15:0] tgtReg;
	logic        cinReg;
	logic [1:0]  remaining;
	logic        accept;
	logic        finish;

	logic [15:0] mulProduct;
	logic        mulCarry;
	logic        mulSignA;
	logic        mulSignB;
	logic        mulFrac;

	logic [7:0]  next_result;
	logic [15:0] next_word;
	logic [7:0]  next_status;
	logic [15:0] next_counter;
	logic        next_destWrite;
	logic        next_wordWrite;
	logic        next_productWrite;
	logic        next_callPush;

	// ops are taken only while idle, so operands never change mid-flight
	assign accept = issueValid && !busy && (issueOp != OP_NONE);
	assign finish = busy && (remaining == 2'd1);

	function automatic logic [1:0] opCycles(input op_t op);
		case (op)
			OP_WORD_ADD_IMM:     opCycles = WORD_CYCLES;
			OP_WORD_SUB_IMM:     opCycles = WORD_CYCLES;
			OP_UNSIGNED_PRODUCT: opCycles = MUL_CYCLES;
			OP_SIGNED_PRODUCT:   opCycles = MUL_CYCLES;
			OP_MIXED_PRODUCT:    opCycles = MUL_CYCLES;
			OP_FRAC_UNSIGNED:    opCycles = MUL_CYCLES;
			OP_FRAC_SIGNED:      opCycles = MUL_CYCLES;
			OP_FRAC_MIXED:       opCycles = MUL_CYCLES;
			OP_REL_BRANCH:       opCycles = REL_BRANCH_CYCLES;
			OP_REL_INVOKE:       opCycles = REL_INVOKE_CYCLES;
			OP_DIRECT_JUMP:      opCycles = DIRECT_CYCLES;
			OP_PTR_BRANCH:       opCycles = PTR_BRANCH_CYCLES;
			OP_PTR_INVOKE:       opCycles = PTR_INVOKE_CYCLES;
			default:             opCycles = ALU_CYCLES;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// issue capture and cycle counting
	// ---------------------------------------------------------------

	// carry is sampled at issue so a register write mid-op cannot skew it
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			opReg  <= OP_NONE;
			dReg   <= 8'h00;
			sReg   <= 8'h00;
			kReg   <= 8'h00;
			wReg   <= 16'h0000;
			wkReg  <= 6'h00;
			ptrReg <= 16'h0000;
			offReg <= 12'h000;
			tgtReg <= 16'h0000;
			cinReg <= 1'b0;
		end else if (accept) begin
			opReg  <= issueOp;
			dReg   <= destValue;
			sReg   <= secondSource;
			kReg   <= immediateValue;
			wReg   <= wordPairValue;
			wkReg  <= wordImmediate;
			ptrReg <= pointerPair;
			offReg <= jumpOffset;
			tgtReg <= jumpTarget;
			cinReg <= statusFlags[FLAG_CARRY];
		end
	end

	// busy spans exactly the op's cycle count after the issue edge
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			remaining <= 2'd0;
			busy      <= 1'b0;
		end else if (accept) begin
			remaining <= opCycles(issueOp);
			busy      <= 1'b1;
		end else if (busy) begin
			remaining <= remaining - 2'd1;
			busy      <= !finish;
		end
	end

	// ---------------------------------------------------------------
	// multiplier
	// ---------------------------------------------------------------

	// signedness per form; mixed means signed destination, unsigned source
	always_comb begin
		mulSignA = (opReg == OP_SIGNED_PRODUCT) || (opReg == OP_MIXED_PRODUCT)
			|| (opReg == OP_FRAC_SIGNED) || (opReg == OP_FRAC_MIXED);
		mulSignB = (opReg == OP_SIGNED_PRODUCT) || (opReg == OP_FRAC_SIGNED);
		mulFrac  = (opReg == OP_FRAC_UNSIGNED) || (opReg == OP_FRAC_SIGNED)
			|| (opReg == OP_FRAC_MIXED);
	end

	product_unit mulStage (
		.core_clk   (core_clk),
		.rstn       (rstn),
		.opA        (dReg),
		.opB        (sReg),
		.signA      (mulSignA),
		.signB      (mulSignB),
		.fractional (mulFrac),
		.product    (mulProduct),
		.carryOut   (mulCarry)
	);

	// ---------------------------------------------------------------
	// result and flag computation
	// ---------------------------------------------------------------

	// one shared adder serves every byte add and subtract and the arithmetic invert
	always_comb begin
		logic [7:0]  a;
		logic [7:0]  b;
		logic        cin;
		logic        isSub;
		logic [8:0]  sum9;
		logic [4:0]  nib5;
		logic [16:0] w17;
		logic        ovf;
		a       = dReg;
		b       = sReg;
		cin     = 1'b0;
		isSub   = 1'b0;
		sum9    = 9'h000;
		nib5    = 5'h00;
		w17     = 17'h00000;
		ovf     = 1'b0;
		next_result       = dReg;
		next_word         = wReg;
		next_status       = statusFlags;
		next_counter      = programCounter + 16'h0001;
		next_destWrite    = 1'b0;
		next_wordWrite    = 1'b0;
		next_productWrite = 1'b0;
		next_callPush     = 1'b0;
		case (opReg)
			OP_REG_ADD: ;
			OP_REG_ADD_CARRY: begin
				cin     = cinReg;
			end
			OP_REG_SUB: begin
				isSub   = 1'b1;
			end
			OP_REG_SUB_BORROW: begin
				isSub   = 1'b1;
				cin     = cinReg;
			end
			OP_CONST_SUB: begin
				isSub   = 1'b1;
				b       = kReg;
			end
			OP_CONST_SUB_BORROW: begin
				isSub   = 1'b1;
				b       = kReg;
				cin     = cinReg;
			end
			OP_ARITH_INVERT: begin
				isSub   = 1'b1;
				a       = 8'h00;
				b       = dReg;
			end
			OP_REG_AND:          next_result = dReg & sReg;
			OP_CONST_AND:        next_result = dReg & kReg;
			OP_REG_OR:           next_result = dReg | sReg;
			OP_CONST_OR:         next_result = dReg | kReg;
			OP_REG_XOR:          next_result = dReg ^ sReg;
			OP_BIT_SET_MASK:     next_result = dReg | kReg;
			OP_BIT_CLEAR_MASK:   next_result = dReg & (8'hff - kReg);
			OP_ZERO_MINUS_CHECK: next_result = dReg & dReg;
			OP_BIT_INVERSION:    next_result = 8'hff - dReg;
			default: ;
		endcase

		// byte adder with separate nibble path for the half carry
		if (isSub) begin
			sum9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
			nib5 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
			ovf  = (a[7] & ~b[7] & ~sum9[7]) | (~a[7] & b[7] & sum9[7]);
		end else begin
			sum9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
			nib5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
			ovf  = (a[7] & b[7] & ~sum9[7]) | (~a[7] & ~b[7] & sum9[7]);
		end

		// word adder; constant is zero extended
		if (opReg == OP_WORD_SUB_IMM) begin
			w17 = {1'b0, wReg} - {11'h000, wkReg};
		end else begin
			w17 = {1'b0, wReg} + {11'h000, wkReg};
		end

		case (opReg)
			OP_REG_ADD, OP_REG_ADD_CARRY, OP_REG_SUB, OP_REG_SUB_BORROW,
			OP_CONST_SUB, OP_CONST_SUB_BORROW, OP_ARITH_INVERT: begin
				next_result                = sum9[7:0];
				next_destWrite             = 1'b1;
				next_status[FLAG_NULL]     = (sum9[7:0] == 8'h00);
				next_status[FLAG_CARRY]    = sum9[8];
				next_status[FLAG_TOP]      = sum9[7];
				next_status[FLAG_RANGE]    = ovf;
				next_status[FLAG_NIBBLE]   = nib5[4];
			end
			OP_REG_AND, OP_CONST_AND, OP_REG_OR, OP_CONST_OR, OP_REG_XOR,
			OP_BIT_SET_MASK, OP_BIT_CLEAR_MASK, OP_ZERO_MINUS_CHECK,
			OP_BIT_INVERSION: begin
				// logic ops never overflow, so the range flag is cleared
				next_destWrite             = 1'b1;
				next_status[FLAG_NULL]     = (next_result == 8'h00);
				next_status[FLAG_TOP]      = next_result[7];
				next_status[FLAG_RANGE]    = 1'b0;
				if (opReg == OP_BIT_INVERSION) begin
					next_status[FLAG_CARRY] = 1'b1;
				end
			end
			OP_WORD_ADD_IMM, OP_WORD_SUB_IMM: begin
				next_word                  = w17[15:0];
				next_wordWrite             = 1'b1;
				next_status[FLAG_NULL]     = (w17[15:0] == 16'h0000);
				next_status[FLAG_CARRY]    = w17[16];
				next_status[FLAG_TOP]      = w17[15];
				next_status[FLAG_RANGE]    = (opReg == OP_WORD_SUB_IMM)
					? (wReg[15] & ~w17[15]) : (~wReg[15] & w17[15]);
				next_status[FLAG_SIGN]     = w17[15] ^ next_status[FLAG_RANGE];
			end
			OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_PRODUCT,
			OP_FRAC_UNSIGNED, OP_FRAC_SIGNED, OP_FRAC_MIXED: begin
				next_productWrite          = 1'b1;
				next_status[FLAG_NULL]     = (mulProduct == 16'h0000);
				next_status[FLAG_CARRY]    = mulCarry;
			end
			OP_REL_BRANCH, OP_REL_INVOKE: begin
				next_counter  = programCounter + {{4{offReg[11]}}, offReg}
					+ 16'h0001;
				next_callPush = (opReg == OP_REL_INVOKE);
			end
			OP_DIRECT_JUMP:  next_counter = tgtReg;
			OP_PTR_BRANCH:   next_counter = ptrReg;
			OP_PTR_INVOKE: begin
				next_counter  = ptrReg;
				next_callPush = 1'b1;
			end
			default: ;
		endcase
	end

	// ---------------------------------------------------------------
	// completion outputs
	// ---------------------------------------------------------------

	// strobes are one-cycle pulses on the done edge
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			done         <= 1'b0;
			destWrite    <= 1'b0;
			wordWrite    <= 1'b0;
			productWrite <= 1'b0;
			callPush     <= 1'b0;
		end else begin
			done         <= finish;
			destWrite    <= finish && next_destWrite;
			wordWrite    <= finish && next_wordWrite;
			productWrite <= finish && next_productWrite;
			callPush     <= finish && next_callPush;
		end
	end

	// data outputs hold their last value between ops
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			destResult  <= 8'h00;
			wordResult  <= 16'h0000;
			productPair <= PRODUCT_RESET;
			returnAddr  <= COUNTER_RESET;
		end else if (finish) begin
			destResult <= next_result;
			wordResult <= next_word;
			if (next_productWrite) begin
				productPair <= mulProduct;
			end
			returnAddr <= programCounter + 16'h0001;
		end
	end

	// a finishing op outranks a software write in the same cycle
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			statusFlags <= STATUS_RESET;
		end else if (finish) begin
			statusFlags <= next_status;
		end else if (regWrite && (regAddr == REG_STATUS)) begin
			statusFlags <= regWrData;
		end
	end

	// counter steps by one after non-jump ops, software may reload it
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			programCounter <= COUNTER_RESET;
		end else if (finish) begin
			programCounter <= next_counter;
		end else if (regWrite && (regAddr == REG_COUNTER_LO)) begin
			programCounter <= {programCounter[15:8], regWrData};
		end else if (regWrite && (regAddr == REG_COUNTER_HI)) begin
			programCounter <= {regWrData, programCounter[7:0]};
		end
	end

	// ---------------------------------------------------------------
	// register port read side
	// ---------------------------------------------------------------

	// read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			regRdData <= 8'h00;
		end else if (regRead) begin
			case (regAddr)
				REG_STATUS:     regRdData <= statusFlags;
				REG_COUNTER_LO: regRdData <= programCounter[7:0];
				REG_COUNTER_HI: regRdData <= programCounter[15:8];
				REG_PRODUCT_LO: regRdData <= productPair[7:0];
				REG_PRODUCT_HI: regRdData <= productPair[15:8];
				REG_RESULT:     regRdData <= destResult;
				default:        regRdData <= 8'h00;
			endcase
		end else begin
			regRdData <= 8'h00;
		end
	end

endmodule

//--- tb/alu_jump_properties.sv
// Purpose: timing and result properties of the execution datapath
// Assumes: one clock domain, decoder issues only while idle
// Notes:   bound to the datapath module at the foot of this file
`timescale 1ns/1ps
module alu_jump_properties (
	input wire logic              core_clk,       // clock
	input wire logic              rstn,           // reset, low
	input wire logic              issueValid,     // issue
	input wire alu_jump_pkg::op_t issueOp,        // op
	input wire logic [7:0]        destValue,      // dest in
	input wire logic [7:0]        secondSource,   // source in
	input wire logic [15:0]       pointerPair,    // pointer
	input wire logic              busy,           // busy
	input wire logic              done,           // done
	input wire logic              destWrite,      // dest pulse
	input wire logic [7:0]        destResult,     // dest out
	input wire logic              wordWrite,      // word pulse
	input wire logic              productWrite,   // product pulse
	input wire logic [15:0]       productPair,    // product
	input wire logic [7:0]        statusFlags,    // flags
	input wire logic              callPush,       // call pulse
	input wire logic [15:0]       programCounter  // counter
);
	import alu_jump_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// an op is taken only while idle
	wire take = issueValid && !busy;
	// ----------------------------------------
	// latency and result relations
	// ----------------------------------------
	property p_add; take && issueOp == OP_REG_ADD |=> ##1 done && destWrite
		&& destResult == 8'($past(destValue, 2) + $past(secondSource, 2)); endproperty
	property p_word; take && issueOp == OP_WORD_ADD_IMM |=> !done [*2] ##1 done && wordWrite;
	endproperty
	property p_mul; take && issueOp == OP_UNSIGNED_PRODUCT |=> !done [*2] ##1 productWrite
		&& productPair == 16'($past(destValue, 3)) * 16'($past(secondSource, 3)); endproperty
	property p_null; productWrite |-> statusFlags[FLAG_NULL] == (productPair == 16'h0000);
	endproperty
	property p_logic; take && issueOp inside {OP_REG_AND, OP_CONST_AND}
		|=> ##1 $stable(statusFlags[FLAG_CARRY]) && !statusFlags[FLAG_RANGE]; endproperty
	property p_ptr; take && issueOp == OP_PTR_BRANCH
		|-> ##3 done && programCounter == $past(pointerPair, 3); endproperty
	property p_call; take && issueOp == OP_PTR_INVOKE |=> !done [*3] ##1 callPush
		&& programCounter == $past(pointerPair, 4); endproperty
	property p_kept; callPush |-> $stable(statusFlags); endproperty
	a_add: assert property (p_add) else $error("add result or latency wrong");
	a_word: assert property (p_word) else $error("word op latency wrong");
	a_mul: assert property (p_mul) else $error("product wrong");
	a_null: assert property (p_null) else $error("product null flag wrong");
	a_logic: assert property (p_logic) else $error("logic op flags wrong");
	a_ptr: assert property (p_ptr) else $error("pointer branch wrong");
	a_call: assert property (p_call) else $error("pointer invoke wrong");
	a_kept: assert property (p_kept) else $error("invoke touched flags");
	c_frac: cover property (take && issueOp == OP_FRAC_SIGNED);
	c_call: cover property (callPush);
	c_word: cover property (wordWrite);
endmodule
bind arith_logic_multiply_jump_unit alu_jump_properties props (.core_clk, .rstn,
	.issueValid, .issueOp, .destValue, .secondSource, .pointerPair, .busy, .done,
	.destWrite, .destResult, .wordWrite, .productWrite, .productPair, .statusFlags,
	.callPush, .programCounter);

//--- tb/issue_model.sv
// Purpose: decoder stand-in that presents one op at a time
// Assumes: bench pulses go only while no request is pending
// Notes:   idle selector reads as no-op so no stale op lingers
`timescale 1ns/1ps
module issue_model (
	input  wire logic              core_clk,   // clock
	input  wire logic              rstn,       // reset, low
	input  wire logic              busy,       // datapath busy
	input  wire logic              go,         // bench wants an issue
	input  wire alu_jump_pkg::op_t opIn,       // op to present
	output logic                   issueValid, // held until taken
	output alu_jump_pkg::op_t      issueOp     // presented op
);
	import alu_jump_pkg::*;
	// hold the request until an idle edge takes it
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			issueValid <= 1'b0;
			issueOp    <= OP_NONE;
		end else if (go) begin
			issueValid <= 1'b1;
			issueOp    <= opIn;
		end else if (issueValid && !busy) begin
			issueValid <= 1'b0;
			issueOp    <= OP_NONE;
		end
	end
endmodule

//--- tb/tb_top.sv
// Purpose: self-checking bench for the execution datapath
// Assumes: operands held from issue until the next op
// Notes:   expected values are worked out by hand below
`timescale 1ns/1ps
module tb_top;
	import alu_jump_pkg::*;
	logic core_clk = 1'b0, rstn = 1'b0, go = 1'b0, regWrite = 1'b0, regRead = 1'b0;
	logic [7:0] destValue = '0, secondSource = '0, immediateValue = '0, regWrData = '0;
	logic [15:0] wordPairValue = '0, pointerPair = '0;
	logic [11:0] jumpOffset = '0;
	logic [5:0] wordImmediate = '0;
	logic [2:0] regAddr = '0;
	op_t opIn = OP_NONE, issueOp;
	logic issueValid, busy, done, destWrite, wordWrite, productWrite, callPush;
	logic [7:0] regRdData, destResult, statusFlags;
	logic [15:0] wordResult, productPair, programCounter, returnAddr;
	int fail_count = 0, compares = 0;
	issue_model dec (.core_clk, .rstn, .busy, .go, .opIn, .issueValid, .issueOp);
	arith_logic_multiply_jump_unit dut (.core_clk, .rstn, .issueValid, .issueOp, .destValue,
		.secondSource, .immediateValue, .wordPairValue, .wordImmediate, .pointerPair,
		.jumpOffset, .jumpTarget(pointerPair), .regAddr, .regWrData, .regWrite, .regRead,
		.regRdData, .busy, .done, .destWrite, .destResult, .wordWrite, .wordResult,
		.productWrite, .productPair, .statusFlags, .programCounter, .callPush, .returnAddr);
	// 100 MHz core clock
	always #5 core_clk = ~core_clk;
	// ----------------------------------------
	// shared bus and compare tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// bounded wait so a lost done cannot hang the run
	task automatic run(input op_t o, input logic [7:0] d, s, k, input logic [15:0] w);
		int i = 0;
		@(posedge core_clk);
		{opIn, destValue, secondSource, immediateValue} <= {o, d, s, k};
		{wordPairValue, pointerPair, jumpOffset, wordImmediate} <= {w, w, w[11:0], k[5:0]};
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		do begin @(posedge core_clk); #1; i++; end while (done !== 1'b1 && i < 8);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge core_clk);
		{regAddr, regWrData, regWrite} <= {a, v, 1'b1};
		@(posedge core_clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge core_clk);
		{regAddr, regRead} <= {a, 1'b1};
		@(posedge core_clk);
		regRead <= 1'b0;
		#1 chk(regRdData, e);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_arith;
		run(OP_REG_ADD, 8'hf8, 8'h08, 8'h00, 16'h0000);
		chk({destResult, statusFlags}, 16'h0023);
		run(OP_REG_ADD_CARRY, 8'h01, 8'h01, 8'h00, 16'h0000);
		chk({destResult, statusFlags}, 16'h0300);
		run(OP_WORD_ADD_IMM, 8'h00, 8'h00, 8'h01, 16'hffff);
		chk(wordResult, 16'h0000);
		chk(statusFlags, 16'h0003);
		run(OP_REG_SUB, 8'h00, 8'h01, 8'h00, 16'h0000);
		chk({destResult, statusFlags}, 16'hff25);
		run(OP_CONST_SUB_BORROW, 8'h10, 8'h00, 8'h0f, 16'h0000);
		chk({destResult, statusFlags}, 16'h0022);
		run(OP_CONST_SUB, 8'h10, 8'h00, 8'h11, 16'h0000);
		chk({destResult, statusFlags}, 16'hff25);
		run(OP_WORD_SUB_IMM, 8'h00, 8'h00, 8'h01, 16'h8000);
		chk(wordResult, 16'h7fff);
		chk(statusFlags, 16'h0038);
	endtask
	task automatic t_logic;
		op_t o [9] = '{OP_REG_AND, OP_CONST_AND, OP_REG_OR, OP_CONST_OR, OP_REG_XOR,
			OP_BIT_SET_MASK, OP_BIT_CLEAR_MASK, OP_ZERO_MINUS_CHECK, OP_BIT_INVERSION};
		logic [7:0] e [9] = '{8'h03, 8'h81, 8'hcf, 8'he7, 8'hcc, 8'he7, 8'h42, 8'hc3, 8'h3c};
		for (int i = 0; i < 9; i++) begin
			run(o[i], 8'hc3, 8'h0f, 8'ha5, 16'h0000);
			chk({destResult, 7'h00, statusFlags[FLAG_TOP]}, {e[i], 7'h00, e[i][7]});
		end
		run(OP_ARITH_INVERT, 8'hc3, 8'h0f, 8'ha5, 16'h0000);
		chk(destResult, 16'h003d);
	endtask
	task automatic t_mul;
		op_t o [6] = '{OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_PRODUCT,
			OP_FRAC_UNSIGNED, OP_FRAC_SIGNED, OP_FRAC_MIXED};
		logic [7:0] a [6] = '{8'hff, 8'hff, 8'hff, 8'h80, 8'hc0, 8'hff};
		logic [7:0] b [6] = '{8'hff, 8'hff, 8'h02, 8'h80, 8'h40, 8'h02};
		logic [15:0] e [6] = '{16'hfe01, 16'h0001, 16'hfffe, 16'h8000, 16'he000, 16'hfffc};
		for (int i = 0; i < 6; i++) begin
			run(o[i], a[i], b[i], 8'h00, 16'h0000);
			chk(productPair, e[i]);
		end
		chk(statusFlags[FLAG_CARRY], 16'h0001);
		rd(3'h3, 8'hfc);
		rd(3'h7, 8'h00);
	endtask
	task automatic t_jump;
		wr(3'h0, 8'h5a);
		wr(3'h1, 8'h00);
		wr(3'h2, 8'h20);
		run(OP_REL_BRANCH, 8'h00, 8'h00, 8'h00, 16'h0ffe);
		chk(programCounter, 16'h1fff);
		run(OP_PTR_INVOKE, 8'h00, 8'h00, 8'h00, 16'h1234);
		chk(programCounter, 16'h1234);
		chk(returnAddr, 16'h2000);
		rd(3'h0, 8'h5a);
		run(OP_REL_INVOKE, 8'h00, 8'h00, 8'h00, 16'h0010);
		chk({programCounter[7:0], returnAddr[7:0]}, 16'h4535);
		run(OP_PTR_BRANCH, 8'h00, 8'h00, 8'h00, 16'h0abc);
		chk({programCounter[11:0], statusFlags[3:0]}, 16'habca);
		run(OP_DIRECT_JUMP, 8'h00, 8'h00, 8'h00, 16'h0777);
		chk(programCounter, 16'h0777);
	endtask
	task automatic conclude;
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// main sequence after a three-cycle reset
	initial begin
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		t_arith();
		t_logic();
		t_mul();
		t_jump();
		conclude();
	end
	// watchdog well past the 150 or so cycles needed
	initial begin
		#20us;
		fail_count++;
		conclude();
	end
endmodule
